// >>> rtl/cid_core.sv
module cid_core
#(
  parameter int          ADDR_W   = 16,
  parameter logic [15:0] START_PC = 16'h0000,
  parameter logic [15:0] SP_RESET = 16'h00FF
)
(
  input  wire logic              mclk_i,
  input  wire logic              srst_i,
  output logic [ADDR_W-1:0]      mem_addr_o,
  output logic                   mem_rd_o,
  output logic                   mem_wr_o,
  output logic [7:0]             mem_wdata_o,
  input  wire logic [7:0]        mem_rdata_i,
  output logic [7:0]             acc_o,
  output logic [15:0]            index_o,
  output logic [15:0]            stack_o,
  output logic [15:0]            pc_o,
  output logic [7:0]             flags_o,
  output logic                   illegal_o,
  output logic                   instr_done_o
);
  typedef struct packed {
    cid_pkg::cid_state_type st;
    logic [15:0]            pc;
    logic [7:0]             a;
    logic [15:0]            hx;
    logic [15:0]            sp;
    logic [7:0]             condition_flags;
    logic [7:0]             opc;
    logic                   pre;
    cid_pkg::cid_kind_type  kind;
    logic [3:0]             mode;
    logic [2:0]             need;
    logic [2:0]             cnt;
    logic [15:0]            ea;
    logic [15:0]            addr;
    logic                   rd;
    logic                   wr;
    logic [7:0]             wdata;
    logic                   illegal;
    logic                   done;
  } cid_core_type;

  cid_core_type         r_reg;
  cid_core_type         r_next;
  cid_pkg::cid_dec_type dec;
  logic [7:0]           cur_opc;
  logic [3:0]           cur_mode;
  logic [2:0]           cur_need;
  logic                 fin;

  cid_alu_if alu_bus ();

  cid_alu u_alu
  (
    .alu (alu_bus.unit)
  );

  if (ADDR_W != 16)
  begin : g_check
    $error("cid_core serves a 16-bit address bus only");
  end

  // Opcode table for the supported subset; unknown bytes report illegal
  function automatic cid_pkg::cid_dec_type decode(input logic pre, input logic [7:0] opc);
    cid_pkg::cid_dec_type d;
    logic [3:0]           hi;
    logic [3:0]           lo;
    logic                 alu_lo;
    logic                 shf_lo;
    d.kind = cid_pkg::K_BAD;
    d.mode = cid_pkg::M_IMM;
    d.need = cid_pkg::CNT_ONE;
    hi = opc[7:4];
    lo = opc[3:0];
    alu_lo = (lo == cid_pkg::LO_ADC) || (lo == cid_pkg::LO_ADD) || (lo == cid_pkg::LO_AND);
    // Logical left shift shares this encoding
    shf_lo = (lo == cid_pkg::LO_ASL) || (lo == cid_pkg::LO_ASR);
    if (!pre)
    begin
      if (opc == cid_pkg::OPC_BCC)
      begin
        d.kind = cid_pkg::K_BCC;
        d.mode = cid_pkg::M_REL;
        d.need = cid_pkg::REL_CYC;
      end
      else if ((opc == cid_pkg::OPC_AIS) || (opc == cid_pkg::OPC_AIX))
      begin
        d.kind = (opc == cid_pkg::OPC_AIS) ? cid_pkg::K_AIS : cid_pkg::K_AIX;
        d.need = cid_pkg::ADJ_CYC;
      end
      else if (alu_lo && (hi >= cid_pkg::HI_ALU_IMM))
      begin
        d.kind = cid_pkg::K_ALU;
        d.mode = hi - cid_pkg::HI_ALU_IMM;
        d.need = cid_pkg::ALU_CYC[d.mode[2:0]];
      end
      else if (shf_lo && (hi >= cid_pkg::HI_SHF_DIR) && (hi <= cid_pkg::HI_SHF_IX))
      begin
        d.kind = cid_pkg::K_SHF;
        case (hi)
          cid_pkg::HI_SHF_DIR:  d.mode = cid_pkg::M_DIR;
          cid_pkg::HI_SHF_INHA: d.mode = cid_pkg::M_INHA;
          cid_pkg::HI_SHF_INHX: d.mode = cid_pkg::M_INHX;
          cid_pkg::HI_SHF_IX1:  d.mode = cid_pkg::M_IX1;
          default:              d.mode = cid_pkg::M_IX;
        endcase
        d.need = cid_pkg::SHF_CYC[d.mode];
      end
    end
    else if (alu_lo && ((hi == cid_pkg::HI_SP2) || (hi == cid_pkg::HI_SP1)))
    begin
      d.kind = cid_pkg::K_ALU;
      d.mode = (hi == cid_pkg::HI_SP2) ? cid_pkg::M_SP2 : cid_pkg::M_SP1;
      d.need = cid_pkg::ALU_CYC[d.mode[2:0]];
    end
    else if (shf_lo && (hi == cid_pkg::HI_SHF_IX1))
    begin
      d.kind = cid_pkg::K_SHF;
      d.mode = cid_pkg::M_SP1;
      d.need = cid_pkg::SHF_CYC[cid_pkg::M_SP1];
    end
    return d;
  endfunction

  function automatic cid_pkg::cid_op_type op_of(input logic [3:0] lo);
    case (lo)
      cid_pkg::LO_ADC: op_of = cid_pkg::A_ADC;
      cid_pkg::LO_ADD: op_of = cid_pkg::A_ADD;
      cid_pkg::LO_ASL: op_of = cid_pkg::A_ASL;
      cid_pkg::LO_ASR: op_of = cid_pkg::A_ASR;
      default:         op_of = cid_pkg::A_AND;
    endcase
  endfunction

  always_comb
  begin
    r_next = r_reg;
    fin = 1'b0;
    dec = decode(r_reg.pre, mem_rdata_i);
    cur_opc = (r_reg.st == cid_pkg::S_FETCH) ? mem_rdata_i : r_reg.opc;
    cur_mode = (r_reg.st == cid_pkg::S_FETCH) ? dec.mode : r_reg.mode;
    cur_need = (r_reg.st == cid_pkg::S_FETCH) ? dec.need : r_reg.need;
    r_next.cnt = r_reg.cnt + cid_pkg::CNT_ONE;
    r_next.done = 1'b0;
    r_next.illegal = 1'b0;
    alu_bus.op = op_of(cur_opc[3:0]);
    alu_bus.a = r_reg.a;
    alu_bus.ccr_in = r_reg.condition_flags;
    if (cur_mode == cid_pkg::M_INHA)
    begin
      alu_bus.m = r_reg.a;
    end
    else if (cur_mode == cid_pkg::M_INHX)
    begin
      alu_bus.m = r_reg.hx[7:0];
    end
    else
    begin
      alu_bus.m = mem_rdata_i;
    end
    case (r_reg.st)
      cid_pkg::S_FETCH:
      begin
        r_next.pc = r_reg.pc + cid_pkg::WORD_ONE;
        if (!r_reg.pre && (mem_rdata_i == cid_pkg::OPC_PREFIX))
        begin
          r_next.pre = 1'b1;
        end
        else
        begin
          r_next.pre = 1'b0;
          r_next.opc = mem_rdata_i;
          r_next.kind = dec.kind;
          r_next.mode = dec.mode;
          r_next.need = dec.need;
          if (dec.kind == cid_pkg::K_BAD)
          begin
            // Byte is skipped; the next one is taken as a fresh opcode
            r_next.illegal = 1'b1;
            r_next.cnt = cid_pkg::CNT_ZERO;
          end
          else if (dec.mode == cid_pkg::M_INHA)
          begin
            r_next.a = alu_bus.res;
            r_next.condition_flags = alu_bus.ccr_out;
            fin = 1'b1;
          end
          else if (dec.mode == cid_pkg::M_INHX)
          begin
            r_next.hx[7:0] = alu_bus.res;
            r_next.condition_flags = alu_bus.ccr_out;
            fin = 1'b1;
          end
          else if (dec.mode == cid_pkg::M_IX)
          begin
            // Plain pointer use; no decoded form here ever bumps the index pair
            r_next.ea = r_reg.hx;
            r_next.st = cid_pkg::S_READ;
          end
          else
          begin
            r_next.st = cid_pkg::S_OPND1;
          end
        end
      end
      cid_pkg::S_OPND1:
      begin
        r_next.pc = r_reg.pc + cid_pkg::WORD_ONE;
        case (r_reg.mode)
          cid_pkg::M_IMM:
          begin
            fin = 1'b1;
            if (r_reg.kind == cid_pkg::K_AIS)
            begin
              r_next.sp = r_reg.sp + {{8{mem_rdata_i[7]}}, mem_rdata_i};
            end
            else if (r_reg.kind == cid_pkg::K_AIX)
            begin
              r_next.hx = r_reg.hx + {{8{mem_rdata_i[7]}}, mem_rdata_i};
            end
            else
            begin
              r_next.a = alu_bus.res;
              r_next.condition_flags = alu_bus.ccr_out;
            end
          end
          cid_pkg::M_REL:
          begin
            fin = 1'b1;
            if (!r_reg.condition_flags[cid_pkg::CCR_C])
            begin
              // Relative to the byte after the displacement
              r_next.pc = r_reg.pc + cid_pkg::WORD_ONE + {{8{mem_rdata_i[7]}}, mem_rdata_i};
            end
          end
          cid_pkg::M_DIR:
          begin
            r_next.ea = {cid_pkg::PAGE_ZERO_HI, mem_rdata_i};
            r_next.st = cid_pkg::S_READ;
          end
          cid_pkg::M_IX1:
          begin
            r_next.ea = r_reg.hx + {cid_pkg::BYTE_ZERO, mem_rdata_i};
            r_next.st = cid_pkg::S_READ;
          end
          cid_pkg::M_SP1:
          begin
            r_next.ea = r_reg.sp + {cid_pkg::BYTE_ZERO, mem_rdata_i};
            r_next.st = cid_pkg::S_READ;
          end
          default:
          begin
            // Word forms: high byte comes first in the stream
            r_next.ea[15:8] = mem_rdata_i;
            r_next.st = cid_pkg::S_OPND2;
          end
        endcase
      end
      cid_pkg::S_OPND2:
      begin
        r_next.pc = r_reg.pc + cid_pkg::WORD_ONE;
        r_next.st = cid_pkg::S_READ;
        case (r_reg.mode)
          cid_pkg::M_IX2:
          begin
            // Wraps at 64K, so signed and unsigned offsets agree
            r_next.ea = r_reg.hx + {r_reg.ea[15:8], mem_rdata_i};
          end
          cid_pkg::M_SP2:
          begin
            r_next.ea = r_reg.sp + {r_reg.ea[15:8], mem_rdata_i};
          end
          default:
          begin
            r_next.ea = {r_reg.ea[15:8], mem_rdata_i};
          end
        endcase
      end
      cid_pkg::S_READ:
      begin
        r_next.condition_flags = alu_bus.ccr_out;
        if (r_reg.kind == cid_pkg::K_SHF)
        begin
          r_next.wdata = alu_bus.res;
          r_next.st = cid_pkg::S_WRITE;
        end
        else
        begin
          r_next.a = alu_bus.res;
          fin = 1'b1;
        end
      end
      cid_pkg::S_WRITE:
      begin
        fin = 1'b1;
      end
      cid_pkg::S_PAD:
      begin
        fin = 1'b1;
      end
      default:
      begin
        r_next.st = cid_pkg::S_FETCH;
        r_next.cnt = cid_pkg::CNT_ZERO;
      end
    endcase
    // Idle cycles stretch each instruction to its documented length
    if (fin)
    begin
      if (r_next.cnt >= cur_need)
      begin
        r_next.st = cid_pkg::S_FETCH;
        r_next.cnt = cid_pkg::CNT_ZERO;
        r_next.done = 1'b1;
      end
      else
      begin
        r_next.st = cid_pkg::S_PAD;
      end
    end
    // Bus strobes are registered, so they follow the next state
    r_next.rd = 1'b0;
    r_next.wr = 1'b0;
    case (r_next.st)
      cid_pkg::S_FETCH, cid_pkg::S_OPND1, cid_pkg::S_OPND2:
      begin
        r_next.addr = r_next.pc;
        r_next.rd = 1'b1;
      end
      cid_pkg::S_READ:
      begin
        r_next.addr = r_next.ea;
        r_next.rd = 1'b1;
      end
      cid_pkg::S_WRITE:
      begin
        r_next.addr = r_next.ea;
        r_next.wr = 1'b1;
      end
      default:
      begin
        r_next.addr = r_reg.addr;
      end
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      r_reg <= '0;
      r_reg.st <= cid_pkg::S_FETCH;
      r_reg.pc <= START_PC;
      r_reg.addr <= START_PC;
      r_reg.rd <= 1'b1;
      r_reg.sp <= SP_RESET;
      r_reg.condition_flags <= cid_pkg::CCR_RESET;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign mem_addr_o   = r_reg.addr;
  assign mem_rd_o     = r_reg.rd;
  assign mem_wr_o     = r_reg.wr;
  assign mem_wdata_o  = r_reg.wdata;
  assign acc_o        = r_reg.a;
  assign index_o      = r_reg.hx;
  assign stack_o      = r_reg.sp;
  assign pc_o         = r_reg.pc;
  assign flags_o      = r_reg.condition_flags;
  assign illegal_o    = r_reg.illegal;
  assign instr_done_o = r_reg.done;
endmodule

// >>> rtl/cid_pkg.sv
package cid_pkg;
  localparam logic [7:0] OPC_PREFIX   = 8'h9E;
  localparam logic [7:0] OPC_BCC      = 8'h24;
  localparam logic [7:0] OPC_AIS      = 8'hA7;
  localparam logic [7:0] OPC_AIX      = 8'hAF;
  localparam logic [3:0] LO_ADC       = 4'h9;
  localparam logic [3:0] LO_ADD       = 4'hB;
  localparam logic [3:0] LO_AND       = 4'h4;
  localparam logic [3:0] LO_ASL       = 4'h8;
  localparam logic [3:0] LO_ASR       = 4'h7;
  localparam logic [3:0] HI_ALU_IMM   = 4'hA;
  localparam logic [3:0] HI_SHF_DIR   = 4'h3;
  localparam logic [3:0] HI_SHF_INHA  = 4'h4;
  localparam logic [3:0] HI_SHF_INHX  = 4'h5;
  localparam logic [3:0] HI_SHF_IX1   = 4'h6;
  localparam logic [3:0] HI_SHF_IX    = 4'h7;
  localparam logic [3:0] HI_SP2       = 4'hD;
  localparam logic [3:0] HI_SP1       = 4'hE;
  localparam logic [3:0] M_IMM        = 4'h0;
  localparam logic [3:0] M_DIR        = 4'h1;
  localparam logic [3:0] M_EXT        = 4'h2;
  localparam logic [3:0] M_IX2        = 4'h3;
  localparam logic [3:0] M_IX1        = 4'h4;
  localparam logic [3:0] M_IX         = 4'h5;
  localparam logic [3:0] M_SP2        = 4'h6;
  localparam logic [3:0] M_SP1        = 4'h7;
  localparam logic [3:0] M_INHA       = 4'h8;
  localparam logic [3:0] M_INHX       = 4'h9;
  localparam logic [3:0] M_REL        = 4'hA;
  // Bus cycles per mode, indexed by the mode code
  localparam logic [7:0][2:0]  ALU_CYC = {3'h4, 3'h5, 3'h3, 3'h3, 3'h4, 3'h4, 3'h3, 3'h2};
  localparam logic [15:0][2:0] SHF_CYC = {3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1,
                                          3'h6, 3'h0, 3'h4, 3'h5, 3'h0, 3'h0, 3'h5, 3'h0};
  localparam logic [2:0]  ADJ_CYC      = 3'h2;
  localparam logic [2:0]  REL_CYC      = 3'h3;
  localparam int          CCR_V        = 7;
  localparam int          CCR_H        = 4;
  localparam int          CCR_I        = 3;
  localparam int          CCR_N        = 2;
  localparam int          CCR_Z        = 1;
  localparam int          CCR_C        = 0;
  localparam logic [7:0]  CCR_RESET    = 8'h08;
  localparam logic [7:0]  PAGE_ZERO_HI = 8'h00;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [15:0] WORD_ONE     = 16'h0001;
  localparam logic [2:0]  CNT_ONE      = 3'h1;
  localparam logic [2:0]  CNT_ZERO     = 3'h0;

  typedef enum logic [2:0] {S_FETCH, S_OPND1, S_OPND2, S_READ, S_WRITE, S_PAD} cid_state_type;
  typedef enum logic [2:0] {K_BAD, K_ALU, K_SHF, K_AIS, K_AIX, K_BCC} cid_kind_type;
  typedef enum logic [2:0] {A_ADC, A_ADD, A_AND, A_ASL, A_ASR} cid_op_type;

  typedef struct packed {
    cid_kind_type kind;
    logic [3:0]   mode;
    logic [2:0]   need;
  } cid_dec_type;
endpackage

// >>> rtl/cid_alu_if.sv
interface cid_alu_if;
  cid_pkg::cid_op_type op;
  logic [7:0]          a;
  logic [7:0]          m;
  logic [7:0]          ccr_in;
  logic [7:0]          res;
  logic [7:0]          ccr_out;
  modport core (output op, a, m, ccr_in, input res, ccr_out);
  modport unit (input op, a, m, ccr_in, output res, ccr_out);
endinterface

// >>> rtl/cid_alu.sv
module cid_alu
(
  cid_alu_if.unit alu
);
  logic [8:0] sum;
  logic [7:0] r;
  logic [7:0] f;

  always_comb
  begin
    f = alu.ccr_in;
    sum = {1'b0, alu.a} + {1'b0, alu.m};
    if (alu.op == cid_pkg::A_ADC)
    begin
      sum = sum + {8'h00, alu.ccr_in[cid_pkg::CCR_C]};
    end
    r = sum[7:0];
    case (alu.op)
      cid_pkg::A_ADC, cid_pkg::A_ADD:
      begin
        f[cid_pkg::CCR_C] = sum[8];
        f[cid_pkg::CCR_H] = (alu.a[3] & alu.m[3]) | (alu.m[3] & ~r[3]) | (~r[3] & alu.a[3]);
        f[cid_pkg::CCR_V] = (alu.a[7] & alu.m[7] & ~r[7]) | (~alu.a[7] & ~alu.m[7] & r[7]);
      end
      cid_pkg::A_AND:
      begin
        r = alu.a & alu.m;
        f[cid_pkg::CCR_V] = 1'b0;
      end
      cid_pkg::A_ASL:
      begin
        r = {alu.m[6:0], 1'b0};
        f[cid_pkg::CCR_C] = alu.m[7];
        f[cid_pkg::CCR_V] = r[7] ^ alu.m[7];
      end
      cid_pkg::A_ASR:
      begin
        // Sign bit is kept so signed halving works
        r = {alu.m[7], alu.m[7:1]};
        f[cid_pkg::CCR_C] = alu.m[0];
        f[cid_pkg::CCR_V] = r[7] ^ alu.m[0];
      end
      default:
      begin
        r = alu.m;
      end
    endcase
    f[cid_pkg::CCR_N] = r[7];
    f[cid_pkg::CCR_Z] = (r == cid_pkg::BYTE_ZERO);
    alu.res = r;
    alu.ccr_out = f;
  end
endmodule

// >>> test/cid_core_asserts.sv
module cid_core_asserts
#(
  parameter int ADDR_W = 16
)
(
  input wire logic              mclk_i,
  input wire logic              srst_i,
  input wire logic [ADDR_W-1:0] mem_addr_o,
  input wire logic              mem_rd_o,
  input wire logic              mem_wr_o,
  input wire logic [7:0]        mem_wdata_o,
  input wire logic [7:0]        mem_rdata_i,
  input wire logic [7:0]        acc_o,
  input wire logic [15:0]       index_o,
  input wire logic [15:0]       stack_o,
  input wire logic [15:0]       pc_o,
  input wire logic [7:0]        flags_o,
  input wire logic              illegal_o,
  input wire logic              instr_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rdq;
  logic [7:0] rdq2;
  logic [7:0] acc_q;

  // Operand bytes are gone from the bus one cycle later, so keep copies
  always_ff @(posedge mclk_i)
  begin
    rdq   <= mem_rdata_i;
    rdq2  <= rdq;
    acc_q <= acc_o;
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  chk_flags_unused: assert property (flags_o[6:5] == 2'b00)
    else $error("unused flag bits changed");
  chk_dir_page_read: assert property (instr_done_o && mem_rdata_i == 8'hB9 |-> ##2 mem_rd_o && mem_addr_o == {8'h00, rdq})
    else $error("page zero read address wrong");
  chk_dir_write_page: assert property (instr_done_o && mem_rdata_i == 8'h38 |-> ##3 mem_wr_o && mem_addr_o == {8'h00, rdq2})
    else $error("page zero shift write wrong");
  chk_adc_dir_len: assert property (instr_done_o && mem_rdata_i == 8'hB9 |=> !instr_done_o [*2] ##1 instr_done_o)
    else $error("page zero add length wrong");
  chk_adjust_quiet: assert property (instr_done_o && (mem_rdata_i == 8'hA7 || mem_rdata_i == 8'hAF)
    |=> (!instr_done_o && $stable(flags_o)) ##1 (instr_done_o && $stable(flags_o)))
    else $error("adjust length or flags wrong");
  chk_stack_adjust: assert property (instr_done_o && mem_rdata_i == 8'hA7 |-> ##2 stack_o == $past(stack_o, 2) + {{8{rdq[7]}}, rdq})
    else $error("stack adjust sum wrong");
  chk_bcc_target: assert property (instr_done_o && mem_rdata_i == 8'h24 |-> ##3 instr_done_o
    && mem_addr_o == $past(mem_addr_o, 3) + 16'h0002 + (flags_o[0] ? 16'h0000 : {{8{rdq2[7]}}, rdq2}))
    else $error("branch target or length wrong");
  chk_adc_imm_sum: assert property (instr_done_o && mem_rdata_i == 8'hA9
    |-> ##2 acc_o == $past(acc_o, 2) + rdq + ($past(flags_o, 2) & 8'h01))
    else $error("add with carry result wrong");
  chk_and_flags: assert property (instr_done_o && mem_rdata_i == 8'hA4 |-> ##2 !flags_o[7]
    && (flags_o & 8'h11) == ($past(flags_o, 2) & 8'h11) && acc_o == ($past(acc_o, 2) & rdq))
    else $error("conjunction result or flags wrong");
  chk_asl_acc: assert property (instr_done_o && mem_rdata_i == 8'h48
    |=> instr_done_o && acc_o == {acc_q[6:0], 1'b0} && flags_o[0] == acc_q[7])
    else $error("left shift of accumulator wrong");
  chk_asr_acc: assert property (instr_done_o && mem_rdata_i == 8'h47
    |=> instr_done_o && acc_o == {acc_q[7], acc_q[7:1]} && flags_o[0] == acc_q[0])
    else $error("right shift of accumulator wrong");
endmodule

bind cid_core cid_core_asserts #(.ADDR_W(ADDR_W)) i_cid_core_asserts (.mclk_i(mclk_i), .srst_i(srst_i),
  .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o),
  .mem_rdata_i(mem_rdata_i), .acc_o(acc_o), .index_o(index_o), .stack_o(stack_o), .pc_o(pc_o),
  .flags_o(flags_o), .illegal_o(illegal_o), .instr_done_o(instr_done_o));

// >>> test/cid_mem_model.sv
module cid_mem_model
(
  input wire logic        mclk_i,
  input wire logic [15:0] addr_i,
  input wire logic        rd_i,
  input wire logic        wr_i,
  input wire logic [7:0]  wdata_i,
  output logic [7:0]      rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [65536];
  logic [7:0] last_q = 8'h00;

  // Plain always: the bench preloads and clears this array by hierarchical writes
  always @(posedge mclk_i)
  begin
    if (wr_i)
      mem[addr_i] <= wdata_i;
    if (rd_i)
      last_q <= mem[addr_i];
  end

  // Zero-wait read; an idle bus shows the inverse of the last byte, never a stale copy
  assign rdata_o = rd_i ? mem[addr_i] : ~last_q;
endmodule

// >>> test/cid_core_tb_top.sv
module cid_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [15:0] mem_addr_o;
  logic        mem_rd_o;
  logic        mem_wr_o;
  logic [7:0]  mem_wdata_o;
  logic [7:0]  mem_rdata_i;
  logic [7:0]  acc_o;
  logic [15:0] index_o;
  logic [15:0] stack_o;
  logic [15:0] pc_o;
  logic [7:0]  flags_o;
  logic        illegal_o;
  logic        instr_done_o;
  logic [7:0]  a_m;
  logic [7:0]  f_m;
  int          err_total = 0;
  int          n_checks = 0;

  always #5 mclk_i = ~mclk_i;

  cid_core i_cid_core (.mclk_i(mclk_i), .srst_i(srst_i), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
    .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .acc_o(acc_o),
    .index_o(index_o), .stack_o(stack_o), .pc_o(pc_o), .flags_o(flags_o), .illegal_o(illegal_o),
    .instr_done_o(instr_done_o));
  cid_mem_model i_cid_mem_model (.mclk_i(mclk_i), .addr_i(mem_addr_o), .rd_i(mem_rd_o), .wr_i(mem_wr_o),
    .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic load(input logic [15:0] base, input logic [7:0] b[$]);
    foreach (b[i])
      i_cid_mem_model.mem[base + 16'(i)] = b[i];
  endtask

  task automatic chk_mem(input logic [15:0] addr, input logic [7:0] exp);
    check({8'h00, i_cid_mem_model.mem[addr]}, {8'h00, exp}, "memory byte");
  endtask

  // Memory is cleared first so stale bytes of an earlier program cannot mask a fault
  task automatic do_reset();
    for (int i = 0; i < 65536; i++)
      i_cid_mem_model.mem[i] = 8'h00;
    srst_i = 1'b1;
    repeat (3) @(posedge mclk_i);
    #1 srst_i = 1'b0;
    a_m = 8'h00;
    f_m = 8'h08;
  endtask

  // Waits for the end of one instruction and judges length, next fetch address and results
  task automatic step(input int len, input logic [15:0] nxt, input logic [7:0] a, input logic [7:0] f);
    int cnt;
    cnt = 0;
    do
    begin
      @(posedge mclk_i);
      #1 cnt++;
    end
    while (instr_done_o !== 1'b1 && cnt < 20);
    check(16'(cnt), 16'(len), "bus cycles");
    check(mem_addr_o, nxt, "next fetch address");
    check({8'h00, acc_o}, {8'h00, a}, "accumulator");
    check({8'h00, flags_o}, {8'h00, f}, "flags");
  endtask

  function automatic logic [15:0] add_ref(input logic [7:0] a, input logic [7:0] m, input logic [7:0] f,
                                          input logic cin);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, m} + {8'h00, cin};
    h = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
    f[7] = (a[7] == m[7]) && (s[7] != a[7]);
    f[4] = h[4];
    f[2] = s[7];
    f[1] = (s[7:0] == 8'h00);
    f[0] = s[8];
    return {f, s[7:0]};
  endfunction

  // Kind 0 add, 1 add with carry, 2 conjunction
  task automatic alu_step(input int kind, input int len, input logic [15:0] nxt, input logic [7:0] m);
    if (kind == 0)
      {f_m, a_m} = add_ref(a_m, m, f_m, 1'b0);
    else if (kind == 1)
      {f_m, a_m} = add_ref(a_m, m, f_m, f_m[0]);
    else
    begin
      a_m = a_m & m;
      f_m[7] = 1'b0;
      f_m[2] = a_m[7];
      f_m[1] = (a_m == 8'h00);
    end
    step(len, nxt, a_m, f_m);
  endtask

  task automatic test_reset();
    do_reset();
    check(pc_o, 16'h0000, "reset pc");
    check(stack_o, 16'h00FF, "reset stack");
    check({8'h00, flags_o}, {8'h00, cid_pkg::CCR_RESET}, "reset flags");
    check({acc_o, index_o[7:0]}, 16'h0000, "reset acc and index low");
    check({15'h0000, mem_rd_o}, 16'h0001, "reset read");
    $display("test_reset finished");
  endtask

  task automatic test_add();
    do_reset();
    load(16'h0000, '{8'hAB, 8'h7F, 8'hA9, 8'h01, 8'hAB, 8'h80, 8'hA9, 8'h00});
    step(2, 16'h0002, 8'h7F, 8'h08);
    step(2, 16'h0004, 8'h80, 8'h9C);
    step(2, 16'h0006, 8'h00, 8'h8B);
    step(2, 16'h0008, 8'h01, 8'h08);
    $display("test_add finished");
  endtask

  task automatic test_modes();
    do_reset();
    load(16'h0000, '{8'hAF, 8'h40, 8'hA7, 8'hF0, 8'hB9, 8'h30, 8'hCB, 8'h01, 8'h00, 8'hD4, 8'hFF, 8'hC0,
                     8'hE9, 8'hC0, 8'hFB, 8'h9E, 8'hD9, 8'h00, 8'h11, 8'h9E, 8'hE4, 8'hF1, 8'hA4, 8'h0F});
    load(16'h0030, '{8'h81});
    load(16'h0040, '{8'h7F});
    load(16'h0100, '{8'h92});
    load(16'h01E0, '{8'hC3});
    step(2, 16'h0002, 8'h00, 8'h08);
    check(index_o, 16'h0040, "index after adjust");
    step(2, 16'h0004, 8'h00, 8'h08);
    check(stack_o, 16'h00EF, "stack after adjust");
    alu_step(1, 3, 16'h0006, 8'h81);
    alu_step(0, 4, 16'h0009, 8'h92);
    alu_step(2, 4, 16'h000C, 8'hAF);
    alu_step(1, 3, 16'h000E, 8'h92);
    alu_step(0, 3, 16'h000F, 8'h7F);
    alu_step(1, 5, 16'h0013, 8'h92);
    alu_step(2, 4, 16'h0016, 8'hC3);
    alu_step(2, 2, 16'h0018, 8'h0F);
    check(index_o, 16'h0040, "index untouched");
    $display("test_modes finished");
  endtask

  // An undecoded byte and an undecoded byte after the prefix are skipped with a pulse
  task automatic test_illegal();
    do_reset();
    load(16'h0000, '{8'h9D, 8'hAB, 8'h05, 8'h9E, 8'hA9, 8'hA4, 8'h0F});
    @(posedge mclk_i);
    #1 check({15'h0000, illegal_o}, 16'h0001, "illegal pulse");
    step(2, 16'h0003, 8'h05, 8'h08);
    check({15'h0000, illegal_o}, 16'h0000, "illegal pulse ended");
    check(pc_o, 16'h0003, "program counter");
    repeat (2) @(posedge mclk_i);
    #1 check({15'h0000, illegal_o}, 16'h0001, "prefixed illegal pulse");
    step(2, 16'h0007, 8'h05, 8'h08);
    $display("test_illegal finished");
  endtask

  task automatic test_shift();
    do_reset();
    load(16'h0000, '{8'hAB, 8'h81, 8'h48, 8'h47, 8'h37, 8'h30, 8'h38, 8'h31, 8'h57, 8'h9E, 8'h68, 8'h10, 8'h68,
                     8'h20, 8'h77, 8'h24, 8'h02, 8'h9E, 8'h67, 8'h30, 8'h24, 8'h7F, 8'h00, 8'h58, 8'h78, 8'h67,
                     8'h21});
    load(16'h0095, '{8'h24, 8'h80});
    load(16'h0020, '{8'hC0, 8'h02});
    load(16'h0030, '{8'h81, 8'h40});
    load(16'h010F, '{8'h01});
    load(16'h012F, '{8'h80});
    step(2, 16'h0002, 8'h81, 8'h0C);
    step(1, 16'h0003, 8'h02, 8'h89);
    step(1, 16'h0004, 8'h01, 8'h08);
    step(5, 16'h0006, 8'h01, 8'h0D);
    chk_mem(16'h0030, 8'hC0);
    step(5, 16'h0008, 8'h01, 8'h8C);
    chk_mem(16'h0031, 8'h80);
    step(1, 16'h0009, 8'h01, 8'h0A);
    step(6, 16'h000C, 8'h01, 8'h08);
    chk_mem(16'h010F, 8'h02);
    step(5, 16'h000E, 8'h01, 8'h0D);
    chk_mem(16'h0020, 8'h80);
    step(4, 16'h000F, 8'h01, 8'h0D);
    chk_mem(16'h0000, 8'hD5);
    step(3, 16'h0011, 8'h01, 8'h0D);
    step(6, 16'h0014, 8'h01, 8'h8C);
    chk_mem(16'h012F, 8'hC0);
    step(3, 16'h0095, 8'h01, 8'h8C);
    step(3, 16'h0017, 8'h01, 8'h8C);
    step(1, 16'h0018, 8'h01, 8'h0A);
    step(4, 16'h0019, 8'h01, 8'h0D);
    chk_mem(16'h0000, 8'hAA);
    step(5, 16'h001B, 8'h01, 8'h08);
    chk_mem(16'h0021, 8'h01);
    $display("test_shift finished");
  endtask

  initial
  begin
    test_reset();
    test_add();
    test_modes();
    test_shift();
    test_illegal();
    final_report();
  end

  // The tests need well under a thousand cycles; this cuts a hang short
  initial
  begin
    #20000;
    err_total++;
    $display("unexpected at %0t: watchdog expired", $time);
    final_report();
  end
endmodule
